// ### rtl/phase_monitor_led_mux.sv
`default_nettype none

module phase_monitor_led_mux #(
    parameter int unsigned TIMEOUT_CYCLES = phase_monitor_pkg::DROPOUT_TIMEOUT_CYCLES,
    parameter int unsigned BLINK_CYCLES = phase_monitor_pkg::BLINK_HALF_CYCLES,
    parameter int unsigned SELECT_CYCLES = phase_monitor_pkg::SELECT_HALF_CYCLES,
    parameter int unsigned ACC_WIDTH = 48
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Supply monitor
    input wire logic supply_good,
    input wire logic reference_good,
    // Per-phase samples, valid on sample_valid
    input wire logic sample_valid,
    input wire phase_monitor_pkg::phase_in_type phase_a,
    input wire phase_monitor_pkg::phase_in_type phase_b,
    input wire phase_monitor_pkg::phase_in_type phase_c,
    // Indicator pins
    output logic indicator_phase_select,
    output logic phase_a_indicator,
    output logic phase_b_indicator,
    output logic phase_c_indicator,
    // Power and status
    output logic reverse_power_flag,
    output logic signed [ACC_WIDTH-1:0] total_energy,
    output phase_monitor_pkg::monitor_status_type status
);

    localparam int unsigned CW = 32;
    localparam int unsigned PW = phase_monitor_pkg::POWER_WIDTH;
    localparam int unsigned AW = phase_monitor_pkg::SAMPLE_WIDTH - 1;
    localparam logic [AW-1:0] FULL_SCALE = {AW{1'b1}};
    localparam logic [AW-1:0] DROP_LEVEL = AW'((32'(FULL_SCALE) *
        phase_monitor_pkg::DROPOUT_LEVEL_PERCENT) / 100);

    if (TIMEOUT_CYCLES < 2 || BLINK_CYCLES < 1 || SELECT_CYCLES < 1)
    begin : gen_bad_timers
        $error("Timer counts too small");
    end
    if (ACC_WIDTH < PW + 2)
    begin : gen_bad_acc
        $error("Accumulator too narrow");
    end

    // ------------------------------------------------------------
    // Data path reset
    // ------------------------------------------------------------
    // Any bad supply holds everything in its reset state
    logic dp_hold;
    assign dp_hold = !(supply_good && reference_good);

    phase_monitor_pkg::phase_in_type ph [3];
    assign ph[0] = phase_a;
    assign ph[1] = phase_b;
    assign ph[2] = phase_c;

    function automatic logic signed [PW-1:0] phase_power(phase_monitor_pkg::phase_in_type p);
        phase_power = PW'(p.voltage * p.current);
    endfunction

    // ------------------------------------------------------------
    // Per-phase dropout timers and reverse detection
    // ------------------------------------------------------------
    logic [CW-1:0] gap_cnt [3];
    logic [CW-1:0] next_gap_cnt [3];
    logic [CW-1:0] good_cnt [3];
    logic [CW-1:0] next_good_cnt [3];
    logic [2:0] dropout, next_dropout;
    logic [2:0] reverse, next_reverse;
    logic signed [PW-1:0] pwr [3];

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_phase
            assign pwr[g] = phase_power(ph[g]);
            always_comb
            begin
                next_gap_cnt[g] = gap_cnt[g];
                next_good_cnt[g] = good_cnt[g];
                next_dropout[g] = dropout[g];
                next_reverse[g] = reverse[g];
                if (dp_hold)
                begin
                    next_gap_cnt[g] = '0;
                    next_good_cnt[g] = '0;
                    next_dropout[g] = 1'b0;
                    next_reverse[g] = 1'b0;
                end
                else
                begin
                    if (sample_valid && ph[g].zero_cross)
                        next_gap_cnt[g] = '0;
                    else if (gap_cnt[g] < CW'(TIMEOUT_CYCLES))
                        next_gap_cnt[g] = gap_cnt[g] + 1'b1;
                    // Signal is healthy while crossings keep coming and level is high
                    if (gap_cnt[g] >= CW'(TIMEOUT_CYCLES) ||
                        (sample_valid && ph[g].amplitude < DROP_LEVEL))
                        next_good_cnt[g] = '0;
                    else if (good_cnt[g] < CW'(TIMEOUT_CYCLES))
                        next_good_cnt[g] = good_cnt[g] + 1'b1;
                    // Clear needs 150 ms of steady evidence; set needs a 150 ms gap or a single low-amplitude sample
                    if (gap_cnt[g] >= CW'(TIMEOUT_CYCLES))
                        next_dropout[g] = 1'b1;
                    else if (sample_valid && ph[g].amplitude < DROP_LEVEL)
                        next_dropout[g] = 1'b1;
                    else if (good_cnt[g] >= CW'(TIMEOUT_CYCLES))
                        next_dropout[g] = 1'b0;
                    if (sample_valid)
                        next_reverse[g] = pwr[g][PW-1];
                end
            end
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    gap_cnt[g] <= '0;
                    good_cnt[g] <= '0;
                    dropout[g] <= 1'b0;
                    reverse[g] <= 1'b0;
                end
                else
                begin
                    gap_cnt[g] <= next_gap_cnt[g];
                    good_cnt[g] <= next_good_cnt[g];
                    dropout[g] <= next_dropout[g];
                    reverse[g] <= next_reverse[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Sequence tracking
    // ------------------------------------------------------------
    phase_monitor_pkg::seq_state_type seq, next_seq;
    logic seq_fault, next_seq_fault;
    logic [CW-1:0] seq_cnt, next_seq_cnt;
    logic seq_error, next_seq_error;
    logic [2:0] zc;
    assign zc = sample_valid ? {ph[2].zero_cross, ph[1].zero_cross, ph[0].zero_cross} : 3'h0;

    always_comb
    begin
        next_seq = seq;
        next_seq_fault = seq_fault;
        next_seq_cnt = seq_cnt;
        next_seq_error = seq_error;
        if (dp_hold || |dropout)
        begin
            // Order is relearned once all phases are back
            next_seq = phase_monitor_pkg::SEQ_EXPECT_A;
            next_seq_fault = 1'b0;
            next_seq_cnt = '0;
            next_seq_error = 1'b0;
        end
        else
        begin
            if (zc != 3'h0)
            begin
                unique case (seq)
                    phase_monitor_pkg::SEQ_EXPECT_A: next_seq_fault = (zc != 3'h1);
                    phase_monitor_pkg::SEQ_EXPECT_B: next_seq_fault = (zc != 3'h2);
                    phase_monitor_pkg::SEQ_EXPECT_C: next_seq_fault = (zc != 3'h4);
                    default: next_seq_fault = 1'b1;
                endcase
                // Resync to the phase just seen, so a swapped order faults on every crossing
                if (zc[2])
                    next_seq = phase_monitor_pkg::SEQ_EXPECT_A;
                else if (zc[1])
                    next_seq = phase_monitor_pkg::SEQ_EXPECT_C;
                else
                    next_seq = phase_monitor_pkg::SEQ_EXPECT_B;
            end
            // Fault must persist 150 ms before blinking starts
            if (!seq_fault)
                next_seq_cnt = '0;
            else if (seq_cnt < CW'(TIMEOUT_CYCLES))
                next_seq_cnt = seq_cnt + 1'b1;
            if (seq_cnt >= CW'(TIMEOUT_CYCLES))
                next_seq_error = 1'b1;
            else if (!seq_fault)
                next_seq_error = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            seq <= phase_monitor_pkg::SEQ_EXPECT_A;
            seq_fault <= 1'b0;
            seq_cnt <= '0;
            seq_error <= 1'b0;
        end
        else
        begin
            seq <= next_seq;
            seq_fault <= next_seq_fault;
            seq_cnt <= next_seq_cnt;
            seq_error <= next_seq_error;
        end
    end

    // ------------------------------------------------------------
    // Energy accumulation
    // ------------------------------------------------------------
    logic signed [ACC_WIDTH-1:0] next_total_energy;
    logic next_reverse_power_flag;
    logic signed [PW+1:0] sum_power;
    assign sum_power = (PW+2)'(pwr[0]) + (PW+2)'(pwr[1]) + (PW+2)'(pwr[2]);

    always_comb
    begin
        next_total_energy = total_energy;
        next_reverse_power_flag = reverse_power_flag;
        if (dp_hold)
        begin
            next_total_energy = '0;
            next_reverse_power_flag = 1'b0;
        end
        else if (sample_valid)
        begin
            // Dropout has no effect here: accumulation never pauses
            next_total_energy = total_energy + ACC_WIDTH'(sum_power);
            next_reverse_power_flag = sum_power[PW+1];
        end
    end

    // ------------------------------------------------------------
    // Select toggle, blink and pin multiplexing
    // ------------------------------------------------------------
    logic [CW-1:0] sel_cnt, next_sel_cnt;
    logic [CW-1:0] blink_cnt, next_blink_cnt;
    logic blink, next_blink;
    logic next_select;
    logic [2:0] pins, next_pins;
    logic [2:0] seq_drop_on;

    always_comb
    begin
        next_sel_cnt = sel_cnt + 1'b1;
        next_select = indicator_phase_select;
        next_blink_cnt = blink_cnt + 1'b1;
        next_blink = blink;
        // Dropout lights steadily, sequence error blinks all three
        seq_drop_on = dropout | {3{seq_error & blink}};
        if (sel_cnt >= CW'(SELECT_CYCLES - 1))
        begin
            next_sel_cnt = '0;
            next_select = !indicator_phase_select;
        end
        if (blink_cnt >= CW'(BLINK_CYCLES - 1))
        begin
            next_blink_cnt = '0;
            next_blink = !blink;
        end
        // Pins follow the select level the line will show next cycle
        if (next_select)
            next_pins = ~seq_drop_on;
        else
            next_pins = reverse;
        if (dp_hold)
        begin
            next_sel_cnt = '0;
            next_select = 1'b0;
            next_blink_cnt = '0;
            next_blink = 1'b0;
            next_pins = 3'h0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sel_cnt <= '0;
            blink_cnt <= '0;
            blink <= 1'b0;
            indicator_phase_select <= 1'b0;
            pins <= 3'h0;
            total_energy <= '0;
            reverse_power_flag <= 1'b0;
            status <= '0;
        end
        else
        begin
            sel_cnt <= next_sel_cnt;
            blink_cnt <= next_blink_cnt;
            blink <= next_blink;
            indicator_phase_select <= next_select;
            pins <= next_pins;
            total_energy <= next_total_energy;
            reverse_power_flag <= next_reverse_power_flag;
            status <= '{dropout: next_dropout, sequence_error: next_seq_error,
                        reverse: next_reverse};
        end
    end

    assign phase_a_indicator = pins[0];
    assign phase_b_indicator = pins[1];
    assign phase_c_indicator = pins[2];

endmodule

`default_nettype wire

// ### rtl/phase_monitor_pkg.sv
`default_nettype none

package phase_monitor_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned SELECT_TOGGLE_KHZ = 131;
    // Half period of the select toggle, rounded down
    localparam int unsigned SELECT_HALF_CYCLES = CLK_HZ / (SELECT_TOGGLE_KHZ * 1000 * 2);
    localparam int unsigned BLINK_HZ = 1;
    localparam int unsigned BLINK_HALF_CYCLES = CLK_HZ / (BLINK_HZ * 2);
    localparam int unsigned DROPOUT_TIMEOUT_MS = 150;
    localparam int unsigned DROPOUT_TIMEOUT_CYCLES = CLK_HZ / 1000 * DROPOUT_TIMEOUT_MS;

    // ------------------------------------------------------------
    // Amplitude threshold
    // ------------------------------------------------------------
    localparam int unsigned DROPOUT_LEVEL_PERCENT = 20;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    localparam int unsigned SAMPLE_WIDTH = 16;
    localparam int unsigned POWER_WIDTH = 2 * SAMPLE_WIDTH + 2;

    typedef struct packed {
        logic signed [SAMPLE_WIDTH-1:0] voltage;
        logic signed [SAMPLE_WIDTH-1:0] current;
        logic [SAMPLE_WIDTH-2:0] amplitude;
        logic zero_cross;
    } phase_in_type;

    typedef struct packed {
        logic [2:0] dropout;
        logic sequence_error;
        logic [2:0] reverse;
    } monitor_status_type;

    typedef enum logic [1:0] {
        SEQ_EXPECT_A,
        SEQ_EXPECT_B,
        SEQ_EXPECT_C
    } seq_state_type;

endpackage

`default_nettype wire

// ### tb/phase_monitor_checker_sva.sv
`default_nettype none

module phase_monitor_checker #(
    parameter int unsigned SELECT_CYCLES = 4,
    parameter int unsigned ACC_WIDTH = 48
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Monitor inputs
    input wire logic supply_good,
    input wire logic reference_good,
    input wire logic sample_valid,
    input wire phase_monitor_pkg::phase_in_type phase_a,
    input wire phase_monitor_pkg::phase_in_type phase_b,
    input wire phase_monitor_pkg::phase_in_type phase_c,
    // Monitor outputs
    input wire logic indicator_phase_select,
    input wire logic phase_a_indicator,
    input wire logic phase_b_indicator,
    input wire logic phase_c_indicator,
    input wire logic reverse_power_flag,
    input wire logic signed [ACC_WIDTH-1:0] total_energy,
    input wire phase_monitor_pkg::monitor_status_type status
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    // Full scale amplitude is 15 bits
    localparam int unsigned DROP_LEVEL = 32767 * 20 / 100;
    logic good;
    logic [2:0] pins;
    logic [2:0] neg;
    logic signed [31:0] pa, pb, pc;
    logic signed [ACC_WIDTH-1:0] psum;
    logic sel_last;
    logic [7:0] run;
    logic [7:0] next_run;
    always_comb
    begin
        good = supply_good && reference_good;
        pins = {phase_c_indicator, phase_b_indicator, phase_a_indicator};
        pa = $signed(phase_a.voltage) * $signed(phase_a.current);
        pb = $signed(phase_b.voltage) * $signed(phase_b.current);
        pc = $signed(phase_c.voltage) * $signed(phase_c.current);
        neg = {pc < 0, pb < 0, pa < 0};
        psum = pa + pb + pc;
        // Run length of the select level; a hold restarts it
        next_run = (good && indicator_phase_select == sel_last) ? run + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            run <= 8'h00;
            sel_last <= 1'b0;
        end
        else
        begin
            run <= next_run;
            sel_last <= indicator_phase_select;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    property p_hold;
        !good |=> {status, reverse_power_flag, indicator_phase_select, pins} == '0
            && total_energy == '0;
    endproperty
    a_hold: assert property (p_hold) else $error("outputs active while held");
    // One extra cycle allowed for the first run after a hold
    property p_select;
        good |-> run < SELECT_CYCLES + 1;
    endproperty
    a_select: assert property (p_select) else $error("select stalled");
    property p_reverse;
        sample_valid && good |=> status.reverse == $past(neg);
    endproperty
    a_reverse: assert property (p_reverse) else $error("reverse flags wrong");
    property p_energy;
        sample_valid && good |=> total_energy == $past(total_energy) + $past(psum)
            && reverse_power_flag == ($past(psum) < 0);
    endproperty
    a_energy: assert property (p_energy) else $error("energy sum wrong");
    property p_prio;
        status.dropout != 3'h0 ##1 status.dropout != 3'h0 |-> !status.sequence_error;
    endproperty
    a_prio: assert property (p_prio) else $error("sequence error during dropout");
    property p_low;
        sample_valid && good && phase_a.amplitude < DROP_LEVEL |=> status.dropout[0];
    endproperty
    a_low: assert property (p_low) else $error("low amplitude missed");
    property p_drop_pins;
        $rose(indicator_phase_select) && $past(good) && $past(status, 1) == $past(status, 2)
            && !$past(status.sequence_error) |-> pins == ~$past(status.dropout);
    endproperty
    a_drop_pins: assert property (p_drop_pins) else $error("dropout pins wrong");
    property p_rev_pins;
        $fell(indicator_phase_select) && $past(good) && $past(status, 1) == $past(status, 2)
            |-> pins == $past(status.reverse);
    endproperty
    a_rev_pins: assert property (p_rev_pins) else $error("reverse pins wrong");
    c_seq: cover property ($rose(status.sequence_error));
    c_drop: cover property ($rose(indicator_phase_select) && status.dropout == 3'h7);
    c_rev: cover property ($fell(indicator_phase_select) && status.reverse != 3'h0);
endmodule

bind phase_monitor_led_mux phase_monitor_checker #(
    .SELECT_CYCLES(SELECT_CYCLES), .ACC_WIDTH(ACC_WIDTH)
) i_phase_monitor_checker (
    .clk(clk), .sys_rst(sys_rst), .supply_good(supply_good),
    .reference_good(reference_good), .sample_valid(sample_valid),
    .phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c),
    .indicator_phase_select(indicator_phase_select), .phase_a_indicator(phase_a_indicator),
    .phase_b_indicator(phase_b_indicator), .phase_c_indicator(phase_c_indicator),
    .reverse_power_flag(reverse_power_flag), .total_energy(total_energy), .status(status)
);

`default_nettype wire

// ### tb/led_lamps.sv
`default_nettype none

module led_lamps (
    // Clock
    input wire logic clk,
    // Indicator pins
    input wire logic indicator_phase_select,
    input wire logic [2:0] pins,
    // Lamps seen lit
    output logic [2:0] drop_lit,
    output logic [2:0] rev_lit
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Lamp pairs
    // ----------------------------------------
    // Each lamp keeps its last level while the other of its pair is driven
    always_ff @(posedge clk)
    begin
        if (indicator_phase_select)
        begin
            drop_lit <= ~pins;
        end
        else
        begin
            rev_lit <= pins;
        end
    end
endmodule

`default_nettype wire

// ### tb/test_phase_monitor_led_mux.sv
`default_nettype none

module test_phase_monitor_led_mux;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    localparam int unsigned SEL = 4;
    localparam int unsigned TMO = 50;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic supply_good = 1'b1;
    logic reference_good = 1'b1;
    logic sample_valid = 1'b0;
    phase_monitor_pkg::phase_in_type phase_a = '0;
    phase_monitor_pkg::phase_in_type phase_b = '0;
    phase_monitor_pkg::phase_in_type phase_c = '0;
    logic sel;
    wire logic [2:0] pins;
    logic rev_flag;
    logic signed [47:0] energy;
    logic signed [47:0] exp_energy = '0;
    phase_monitor_pkg::monitor_status_type status;
    logic [2:0] drop_lit;
    logic [2:0] rev_lit;
    int fails = 0;
    int checks_done = 0;
    phase_monitor_led_mux #(
        .TIMEOUT_CYCLES(TMO), .BLINK_CYCLES(20), .SELECT_CYCLES(SEL), .ACC_WIDTH(48)
    ) i_phase_monitor_led_mux (
        .clk(clk), .sys_rst(sys_rst), .supply_good(supply_good),
        .reference_good(reference_good), .sample_valid(sample_valid),
        .phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c),
        .indicator_phase_select(sel), .phase_a_indicator(pins[0]),
        .phase_b_indicator(pins[1]), .phase_c_indicator(pins[2]),
        .reverse_power_flag(rev_flag), .total_energy(energy), .status(status)
    );
    led_lamps i_led_lamps (
        .clk(clk), .indicator_phase_select(sel), .pins(pins), .drop_lit(drop_lit),
        .rev_lit(rev_lit)
    );
    task automatic check(input string what, input logic [63:0] want, input logic [63:0] got);
        checks_done++;
        if (got !== want)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, want, got);
        end
    endtask
    function automatic phase_monitor_pkg::phase_in_type ph(input logic zc, input logic neg,
        input logic low);
        ph.voltage = 16'h03e8;
        ph.current = neg ? 16'hff38 : 16'h00c8;
        ph.amplitude = low ? 15'h1000 : 15'h7fff;
        ph.zero_cross = zc;
    endfunction
    task automatic send(input logic [2:0] zc, input logic [2:0] neg, input logic [2:0] low);
        @(negedge clk);
        phase_a = ph(zc[0], neg[0], low[0]);
        phase_b = ph(zc[1], neg[1], low[1]);
        phase_c = ph(zc[2], neg[2], low[2]);
        sample_valid = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            exp_energy += neg[i] ? -48'sh30d40 : 48'sh30d40;
        end
        @(negedge clk);
        sample_valid = 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Spacing keeps every phase crossing well inside the timeout
    task automatic trip(input logic [2:0] p0, input logic [2:0] p1, input logic [2:0] p2);
        send(p0, 3'b010, 3'h0);
        idle(3);
        send(p1, 3'b010, 3'h0);
        idle(3);
        send(p2, 3'b010, 3'h0);
        idle(3);
    endtask
    task automatic t_reverse();
        send(3'h0, 3'b011, 3'h0);
        check("reverse", 3'b011, status.reverse);
        check("rev_flag", 1'b1, rev_flag);
        check("energy", exp_energy, energy);
        idle(2 * SEL + 2);
        check("rev_lit", 3'b011, rev_lit);
        send(3'h0, 3'b100, 3'h0);
        check("reverse", 3'b100, status.reverse);
        check("rev_flag", 1'b0, rev_flag);
    endtask
    task automatic t_seq();
        logic on;
        logic off;
        on = 1'b0;
        off = 1'b0;
        repeat (8) trip(3'b001, 3'b010, 3'b100);
        check("status", 7'h02, status);
        repeat (2) trip(3'b001, 3'b100, 3'b010);
        check("seq_early", 1'b0, status.sequence_error);
        repeat (2) trip(3'b001, 3'b100, 3'b010);
        repeat (10)
        begin
            trip(3'b001, 3'b100, 3'b010);
            check("status", 7'h0a, status);
            check("rev_lit", 3'b010, rev_lit);
            on |= drop_lit === 3'h7;
            off |= drop_lit === 3'h0;
        end
        check("blink", 2'b11, {on, off});
    endtask
    task automatic t_drop();
        idle(TMO + 10);
        check("status", 7'h72, status);
        idle(2 * SEL);
        check("drop_lit", 3'h7, drop_lit);
        send(3'h0, 3'h0, 3'h0);
        check("energy", exp_energy, energy);
        repeat (2) trip(3'b001, 3'b010, 3'b100);
        check("dropout", 3'h7, status.dropout);
        repeat (4) trip(3'b001, 3'b010, 3'b100);
        check("dropout", 3'h0, status.dropout);
        send(3'h0, 3'b001, 3'b001);
        check("status", 7'h11, status);
    endtask
    task automatic t_hold();
        logic seen;
        for (int i = 0; i < 2; i++)
        begin
            seen = 1'b0;
            supply_good = i[0];
            reference_good = !i[0];
            idle(2);
            check("held", 0, {sel, pins, rev_flag, status, energy});
            supply_good = 1'b1;
            reference_good = 1'b1;
            exp_energy = '0;
            repeat (2 * SEL + 2)
            begin
                @(negedge clk);
                seen |= sel;
            end
            check("select", 1'b1, seen);
        end
        send(3'h0, 3'h0, 3'h0);
        check("energy", exp_energy, energy);
    endtask
    task automatic give_verdict();
        if (fails == 0 && checks_done > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial
    begin
        forever #25 clk = ~clk;
    end
    // The whole sequence needs under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        t_reverse();
        t_seq();
        t_drop();
        t_hold();
        give_verdict();
    end
endmodule

`default_nettype wire
